// *** rtl/clfs_sequencer.sv ***
`timescale 1ns/1ns
// Overview of operation
// - overcurrent starts the blanking timer
// - overcurrent gone early clears timer, no action
// - autoretry: after blanking, off for retry
// - retry ends: on again; repeat while faulted
// - flag held low through whole autoretry cycle
// - blanking 16.3ms, retry 521.6ms nominal
// - latch-off: after blanking, off and flagged
// - continuous: stay on, flag after blanking
// - on input polarity selectable, high or low
// - reverse current: off and flag at once
// - reverse clears: switch on, flag released, except in retry or latched off
// - overtemperature: off and flag, restore when cool
// - limit pin shorted asserts the flag
// - retry is exactly 32 blanking units
module clfs_sequencer
  import clfs_pkg::*;
#(
  parameter clfs_mode_type MODE        = CLFS_MODE_RETRY,  // overcurrent response variant
  parameter bit            ON_ACT_LOW  = 1'b0,             // on input active low
  parameter int unsigned   BASE_CYCLES = BLANK_CYCLES      // cycles per blanking interval
) (
  input  wire logic clk_i,              // system clock, 25 MHz
  input  wire logic resetn_i,           // sync reset, active low (power-up)
  input  wire logic switch_on_i,        // switch-on input, polarity per ON_ACT_LOW
  input  wire logic overcurrent_i,      // forward current at limit threshold
  input  wire logic reverse_i,          // reverse current detected (with hysteresis)
  input  wire logic overtemp_i,         // die over temperature (with hysteresis)
  input  wire logic limit_set_pin_i,    // limit_set_pin shorted to ground
  output logic      switch_en_o,        // pass switch on
  output logic      fault_flag_o,       // fault flag pad output, always low level
  output logic      fault_flag_oe_o     // low while pulling the flag low
);

  localparam logic [UNIT_W-1:0] UNITS_BLANK = UNIT_W'(1);
  localparam logic [UNIT_W-1:0] UNITS_RETRY = UNIT_W'(RETRY_RATIO);

  // whole module state
  typedef struct packed {
    clfs_state_type st;                 // sequencer state
    logic           on_prev;            // last sampled on request
    logic           sw;                 // registered switch enable
    logic           flag_oe;            // registered flag enable, low = pulling low
  } clfs_seq_type;

  clfs_seq_type s_q;
  clfs_seq_type s_d;

  logic             on_req;             // on request after polarity
  logic             tmr_clear;          // restart interval timer
  logic [UNIT_W-1:0] tmr_units;         // interval length in units
  logic             tmr_done;           // interval elapsed
  logic             hard_fault;         // reverse or thermal condition

  assign on_req     = switch_on_i ^ ON_ACT_LOW;
  assign hard_fault = reverse_i | overtemp_i;

  // shared oscillator, blanking one unit, retry 32 units
  clfs_timer #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (tmr_clear),
    .units_i  (tmr_units),
    .done_o   (tmr_done)
  );

  // timer length follows state
  always_comb begin
    tmr_units = (s_q.st == CLFS_ST_RETRY) ? UNITS_RETRY : UNITS_BLANK;
  end

  // sequencer next state
  always_comb begin
    s_d         = s_q;
    tmr_clear   = 1'b1;
    s_d.on_prev = on_req;
    case (s_q.st)
      CLFS_ST_OFF: begin                                   // switch commanded off
        if (on_req) begin
          s_d.st = CLFS_ST_ON;
        end
      end
      CLFS_ST_ON: begin                                    // normal conduction
        if (!on_req) begin
          s_d.st = CLFS_ST_OFF;
        end else if (overcurrent_i && !hard_fault) begin
          s_d.st = CLFS_ST_BLANK;
        end
      end
      CLFS_ST_BLANK: begin                                 // qualifying overcurrent
        tmr_clear = 1'b0;
        if (!on_req) begin
          s_d.st = CLFS_ST_OFF;
        end else if (!overcurrent_i) begin
          s_d.st    = CLFS_ST_ON;
          tmr_clear = 1'b1;
        end else if (tmr_done) begin
          tmr_clear = 1'b1;
          case (MODE)
            CLFS_MODE_RETRY: s_d.st = CLFS_ST_RETRY;
            CLFS_MODE_LATCH: s_d.st = CLFS_ST_LATCHED;
            default:         s_d.st = CLFS_ST_LIMIT;
          endcase
        end
      end
      CLFS_ST_RETRY: begin                                 // switch off for retry
        tmr_clear = 1'b0;
        if (!on_req) begin
          s_d.st = CLFS_ST_OFF;
        end else if (tmr_done) begin
          s_d.st    = CLFS_ST_BLANK;
          tmr_clear = 1'b1;
        end
      end
      CLFS_ST_LATCHED: begin                               // wait for on toggle
        if (!on_req) begin
          s_d.st = CLFS_ST_OFF;
        end
      end
      CLFS_ST_LIMIT: begin                                 // limiting, flag held
        if (!on_req) begin
          s_d.st = CLFS_ST_OFF;
        end else if (!overcurrent_i) begin
          s_d.st = CLFS_ST_ON;
        end
      end
      default: begin
        s_d.st = CLFS_ST_OFF;
      end
    endcase
    // reverse or thermal in blanking or limit forces off, restarts qualification afterwards
    if (hard_fault && (s_q.st == CLFS_ST_BLANK || s_q.st == CLFS_ST_LIMIT)) begin
      s_d.st    = on_req ? CLFS_ST_ON : CLFS_ST_OFF;
      tmr_clear = 1'b1;
    end
    // outputs from next state
    s_d.sw = on_req && !hard_fault &&
             (s_d.st == CLFS_ST_ON || s_d.st == CLFS_ST_BLANK ||
              s_d.st == CLFS_ST_LIMIT);
    s_d.flag_oe = !(hard_fault || limit_set_pin_i ||
               s_d.st == CLFS_ST_RETRY || s_d.st == CLFS_ST_LATCHED ||
               s_d.st == CLFS_ST_LIMIT ||
               (s_q.st == CLFS_ST_RETRY && s_d.st == CLFS_ST_BLANK) ||
               (s_q.st == CLFS_ST_BLANK && !s_q.flag_oe && s_d.st == CLFS_ST_BLANK));
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin                                   // off, flag released
      s_q <= '{st: CLFS_ST_OFF, on_prev: 1'b0, sw: 1'b0, flag_oe: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // open-drain flag: enable low while pulling low
  assign switch_en_o     = s_q.sw;
  assign fault_flag_o    = 1'b0;
  assign fault_flag_oe_o = s_q.flag_oe;

endmodule // clfs_sequencer

// *** rtl/clfs_pkg.sv ***
package clfs_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;

  // nominal intervals as printed
  localparam int unsigned BLANK_US      = 16_300;   // blanking interval, microseconds
  localparam int unsigned RETRY_RATIO   = 32;       // retry interval over blanking interval

  // blanking count in clock cycles, rounded down to whole cycles
  localparam longint unsigned BLANK_CYC_L =
    (64'(BLANK_US) * 64'(CLK_HZ)) / 64'd1_000_000;
  localparam int unsigned BLANK_CYCLES  = 32'(BLANK_CYC_L);

  // one shared base counter: blanking is one unit, retry is RETRY_RATIO units
  localparam int unsigned TICK_W        = 24;       // width of the interval counter
  localparam int unsigned UNIT_W        = 6;        // width of the unit counter

  // response variants
  typedef enum logic [1:0] {
    CLFS_MODE_RETRY,                                // autoretry
    CLFS_MODE_LATCH,                                // latch-off
    CLFS_MODE_CONT                                  // continuous limiting
  } clfs_mode_type;

  // sequencer states
  typedef enum logic [2:0] {
    CLFS_ST_OFF,                                    // switch commanded off
    CLFS_ST_ON,                                     // on, no overcurrent
    CLFS_ST_BLANK,                                  // overcurrent being qualified
    CLFS_ST_RETRY,                                  // retry wait, switch off
    CLFS_ST_LATCHED,                                // latched off
    CLFS_ST_LIMIT                                   // continuous limit, flagged
  } clfs_state_type;

endpackage

// *** rtl/clfs_timer.sv ***
`timescale 1ns/1ns
// shared interval oscillator: one base period counted out in units
module clfs_timer
  import clfs_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BLANK_CYCLES       // cycles of one blanking unit
) (
  input  wire logic              clk_i,                   // system clock
  input  wire logic              resetn_i,                // sync reset, active low
  input  wire logic              clear_i,                 // restart counting from zero
  input  wire logic [UNIT_W-1:0] units_i,                 // units to count before done
  output logic                   done_o                   // level, count reached
);

  // timer state
  typedef struct packed {
    logic [TICK_W-1:0] tick;                              // cycles inside a unit
    logic [UNIT_W-1:0] unit;                              // units completed
    logic              done;                              // target reached
  } clfs_tmr_type;

  clfs_tmr_type s_q;
  clfs_tmr_type s_d;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BASE_CYCLES - 1);

  // next-state: count ticks, then units, stop at target
  always_comb begin
    s_d = s_q;
    if (clear_i) begin                                    // restart
      s_d = '0;
    end else if (!s_q.done) begin
      if (s_q.tick == TICK_LAST) begin                    // unit complete
        s_d.tick = '0;
        s_d.unit = s_q.unit + UNIT_W'(1);
        if (s_q.unit + UNIT_W'(1) == units_i) begin
          s_d.done = 1'b1;
        end
      end else begin
        s_d.tick = s_q.tick + TICK_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;

endmodule // clfs_timer

// *** dv/clfs_chk.sv ***
`timescale 1ns/1ns
// pin checks for the sequencer in autoretry
module clfs_chk
  import clfs_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = 10,   // cycles per blanking unit
  parameter bit          ON_ACT_LOW  = 1'b0  // on input active low
) (
  input wire logic clk_i,           // clock
  input wire logic resetn_i,        // sync reset, low
  input wire logic switch_on_i,     // on request
  input wire logic overcurrent_i,   // at limit
  input wire logic reverse_i,       // reverse current
  input wire logic overtemp_i,      // over temperature
  input wire logic limit_set_pin_i, // pin shorted
  input wire logic switch_en_o,     // switch on
  input wire logic fault_flag_o,    // flag data
  input wire logic fault_flag_oe_o  // low while flagged
);
  logic [15:0] off_cnt_q; // cycles off while requested and free of hard faults
  logic        on_act;    // on request after polarity
  assign on_act = switch_on_i ^ ON_ACT_LOW;
  // restart on any cause other than the overcurrent sequence
  always_ff @(posedge clk_i) begin
    if (!resetn_i || switch_en_o || !on_act || reverse_i || overtemp_i) off_cnt_q <= '0;
    else off_cnt_q <= off_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  off_req_a: assert property (!on_act |=> !switch_en_o)
    else $error("switch on without request");
  rev_off_a: assert property (reverse_i |=> !switch_en_o && !fault_flag_oe_o)
    else $error("reverse current not acted on");
  hot_off_a: assert property (overtemp_i |=> !switch_en_o && !fault_flag_oe_o)
    else $error("over temperature not acted on");
  short_flag_a: assert property (limit_set_pin_i |=> !fault_flag_oe_o)
    else $error("shorted limit pin not flagged");
  flag_data_a: assert property (fault_flag_o == 1'b0)
    else $error("flag data not low");
  blank_qual_a: assert property ($fell(switch_en_o) && $past(on_act) && !$past(reverse_i)
    && !$past(overtemp_i) |-> $past(overcurrent_i, BASE_CYCLES)) else $error("early trip");
  retry_len_a: assert property ($rose(switch_en_o) && off_cnt_q > 3 |->
    off_cnt_q >= 32 * BASE_CYCLES - 1 && off_cnt_q <= 32 * BASE_CYCLES + 2) else $error("retry span");
  retry_flag_a: assert property (off_cnt_q > 2 |-> !fault_flag_oe_o)
    else $error("flag released while off");
  stay_on_a: assert property (switch_en_o && switch_on_i && !overcurrent_i && !reverse_i
    && !overtemp_i |=> switch_en_o) else $error("switch dropped");
endmodule // clfs_chk

bind clfs_sequencer clfs_chk #(.BASE_CYCLES(BASE_CYCLES), .ON_ACT_LOW(ON_ACT_LOW)) chk (.clk_i(clk_i),
  .resetn_i(resetn_i), .switch_on_i(switch_on_i), .overcurrent_i(overcurrent_i),
  .reverse_i(reverse_i), .overtemp_i(overtemp_i), .limit_set_pin_i(limit_set_pin_i),
  .switch_en_o(switch_en_o), .fault_flag_o(fault_flag_o), .fault_flag_oe_o(fault_flag_oe_o));

// *** dv/clfs_host.sv ***
`timescale 1ns/1ns
// host side: drives the on request and pulls the flag line up
module clfs_host (
  input  wire logic on_cmd_i,   // bench wants the switch on
  input  wire logic flag_pad_i, // flag data from device
  input  wire logic flag_oe_i,  // low while device pulls flag
  output logic      on_req_o,   // on request pin
  output logic      flag_n_o    // resolved flag line
);
  assign on_req_o = on_cmd_i;
  assign flag_n_o = flag_oe_i ? 1'b1 : flag_pad_i;
endmodule // clfs_host

// *** dv/tb_clfs_sequencer.sv ***
`timescale 1ns/1ns
// bench: autoretry with a short base interval
module tb_clfs_sequencer;
  import clfs_pkg::*;
  localparam int unsigned B = 10;
  logic       clk_i    = 1'b0; // clock
  logic       resetn_i = 1'b0; // reset
  logic       on_cmd   = 1'b0; // host command
  logic [3:0] flt      = 4'h0; // overcurrent, reverse, hot, pin short
  logic       on_req, sw_en, flag_pad, flag_oe, flag_n; // pins
  logic [1:0] exp_q[$];        // expected {switch, flag line}
  logic [1:0] last     = 2'b01;
  logic       on_req_n, sw2, flag2_pad, flag2_oe, flag2_n; // latch-off unit pins
  logic [1:0] exp2_q[$];       // expected {switch, flag line}, latch-off unit
  logic [1:0] last2    = 2'b01;
  int         err_count = 0, checks_done = 0, cyc = 0;
  always #20 clk_i = ~clk_i;
  clfs_sequencer #(.BASE_CYCLES(B)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .switch_on_i(on_req), .overcurrent_i(flt[0]), .reverse_i(flt[1]), .overtemp_i(flt[2]),
    .limit_set_pin_i(flt[3]), .switch_en_o(sw_en), .fault_flag_o(flag_pad),
    .fault_flag_oe_o(flag_oe));
  clfs_host host (.on_cmd_i(on_cmd), .flag_pad_i(flag_pad), .flag_oe_i(flag_oe),
    .on_req_o(on_req), .flag_n_o(flag_n));
  // latch-off unit with active-low on input, same faults
  assign on_req_n = ~on_req;
  clfs_sequencer #(.MODE(CLFS_MODE_LATCH), .ON_ACT_LOW(1'b1), .BASE_CYCLES(B)) dut2 (
    .clk_i(clk_i), .resetn_i(resetn_i), .switch_on_i(on_req_n), .overcurrent_i(flt[0]),
    .reverse_i(flt[1]), .overtemp_i(flt[2]), .limit_set_pin_i(flt[3]), .switch_en_o(sw2),
    .fault_flag_o(flag2_pad), .fault_flag_oe_o(flag2_oe));
  clfs_host host2 (.on_cmd_i(on_cmd), .flag_pad_i(flag2_pad), .flag_oe_i(flag2_oe),
    .on_req_o(), .flag_n_o(flag2_n));
  task automatic cmp(input logic [1:0] got, input logic [1:0] want);
    checks_done++;
    if (got !== want) begin
      err_count++;
      $display("wrong value at %0t: pins %b expected %b", $time, got, want);
    end
  endtask
  task automatic test_done();
    if (exp_q.size() != 0 || exp2_q.size() != 0) err_count++;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watcher: every change of the pins consumes the oldest note
  always @(posedge clk_i) begin
    #1;
    cyc++;
    if ({sw_en, flag_n} !== last) begin
      last = {sw_en, flag_n};
      if (exp_q.size() == 0) cmp(last, ~last);
      else cmp(last, exp_q.pop_front());
    end
    if ({sw2, flag2_n} !== last2) begin
      last2 = {sw2, flag2_n};
      if (exp2_q.size() == 0) cmp(last2, ~last2);
      else cmp(last2, exp2_q.pop_front());
    end
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end
  // reverse, thermal or pin-short fault held a few cycles, then released
  task automatic pulse(input int idx);
    exp_q.push_back(idx == 3 ? 2'b10 : 2'b00);
    exp_q.push_back(2'b11);
    flt[idx] <= 1'b1;
    repeat (5) @(posedge clk_i);
    flt[idx] <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  initial begin
    void'($urandom(32'h1d00d22d));
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    exp_q.push_back(2'b11);
    exp2_q.push_back(2'b11);
    on_cmd <= 1'b1;
    repeat (4) @(posedge clk_i);
    // bursts shorter than blanking must change nothing
    for (int i = 0; i < 6; i++) begin
      flt[0] <= 1'b1;
      repeat (1 + $urandom % (B - 2)) @(posedge clk_i);
      flt[0] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    exp_q.push_back(2'b00);
    exp2_q.push_back(2'b00);
    exp_q.push_back(2'b10);
    exp_q.push_back(2'b11);
    flt[0] <= 1'b1;
    repeat (B + 3 + 32 * B) @(posedge clk_i);
    flt[0] <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (int i = 1; i < 4; i++) pulse(i);
    exp_q.push_back(2'b01);
    exp2_q.push_back(2'b01);
    on_cmd <= 1'b0;
    repeat (4) @(posedge clk_i);
    exp_q.push_back(2'b11);
    exp2_q.push_back(2'b11);
    on_cmd <= 1'b1;
    repeat (4) @(posedge clk_i);
    test_done();
  end
endmodule // tb_clfs_sequencer
